// >>> rfa_top.sv
// Reading filter with autorange, overflow and continuity beeper, APB slave.
// Assumes conversions arrive as signed microunits on pclk, one per conv_valid strobe.
`include "rfa_map.svh"

// Behaviour
// - Continuity beeps when reading below threshold
// - Threshold accepts only 1 to 1000
// - Threshold resets to 10 ohms
// - Continuity always uses fast rate
// - Diode test always uses medium rate
// - Diode current three choices, default 1mA
// - Diode reading above 10 V overflows
// - Overrange limit 120 percent, some exempt
// - Over limit flags overflow, number still output
// - Range setting kept per function
// - Manual step moves one range
// - Autorange up at 120, down 10
// - Auto off keeps range; step cancels
// - Auto ignored for temp, continuity, diode
// - Filter averages 1 to 100 conversions
// - Moving mode evicts oldest, new average
// - Repeating mode fills, outputs, clears
// - No filtering for continuity_function, diode
// - Filter type, count per function
module rfa_top #(
    parameter int W = 32,
    parameter int DEPTH = 100,
    parameter logic [31:0] FULL_SCALE = 32'h000f_4240
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter stream
    input wire logic conv_valid,
    input wire logic signed [W-1:0] conv_data,
    // Converter setup and indications
    output rfa_pkg::rfa_rate_e conv_rate,
    output rfa_pkg::rfa_diode_e diode_current,
    output logic [2:0] range_sel,
    output logic beep,
    output logic overflow,
    output logic filter_on_indicator,
    output logic rd_valid,
    output logic signed [W-1:0] rd_data
);
    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    rfa_pkg::rfa_func_e func_r;
    logic [9:0] thr_r;
    logic filter_on_indicator_en_r;
    logic [6:0] fcnt_r [8];
    logic ftype_r [8];
    logic [2:0] rng_r [8];
    logic auto_r [8];
    rfa_pkg::rfa_diode_e diode_r;
    logic flush_r;
    logic ovf_r;
    logic [31:0] result_r;
    logic wr;
    logic rd;
    logic mapped;
    logic single_range;
    logic no_filter;
    // Wide enough for the top range full scale, which overflows 32 bits
    logic [63:0] mag;
    logic [63:0] fs;
    logic [63:0] limit;
    logic exempt;
    logic [2:0] cur_rng;
    logic avg_valid;
    logic signed [W-1:0] avg_data;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00 && paddr[4:2] <= 3'h5;
    assign pslverr = psel && penable && !mapped;
    assign cur_rng = rng_r[func_r];
    assign single_range = func_r == rfa_pkg::RFA_TEMP || func_r == rfa_pkg::RFA_CONTINUITY_FUNCTION
        || func_r == rfa_pkg::RFA_DIODE;
    assign no_filter = func_r == rfa_pkg::RFA_CONTINUITY_FUNCTION || func_r == rfa_pkg::RFA_DIODE;
    assign filter_on_indicator = filter_on_indicator_en_r;
    assign range_sel = cur_rng;
    assign diode_current = diode_r;

    // Fixed rates for continuity and diode; others medium
    always_comb begin
        case (func_r)
            rfa_pkg::RFA_CONTINUITY_FUNCTION: conv_rate = rfa_pkg::RFA_FAST;
            rfa_pkg::RFA_DIODE: conv_rate = rfa_pkg::RFA_MED;
            default: conv_rate = rfa_pkg::RFA_MED;
        endcase
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_r <= rfa_pkg::RFA_DCV;
            diode_r <= rfa_pkg::RFA_I1MA;
            filter_on_indicator_en_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            flush_r <= 1'b0;
            if (wr && paddr == `RFA_ADDR_CTRL) begin
                if (rfa_pkg::rfa_func_e'(pwdata[`RFA_CTRL_FUNC_LSB +: 3]) != func_r) begin
                    flush_r <= 1'b1;
                end
                func_r <= rfa_pkg::rfa_func_e'(pwdata[`RFA_CTRL_FUNC_LSB +: 3]);
                if (pwdata[`RFA_CTRL_DIODE_LSB +: 2] != 2'h3) begin
                    diode_r <= rfa_pkg::rfa_diode_e'(pwdata[`RFA_CTRL_DIODE_LSB +: 2]);
                end
                if (pwdata[`RFA_CTRL_FTOG_BIT]) begin
                    filter_on_indicator_en_r <= !filter_on_indicator_en_r;
                    flush_r <= 1'b1;
                end
            end
            if (wr && (paddr == `RFA_ADDR_FILTER_ON_INDICATOR || paddr == `RFA_ADDR_RANGE)) begin
                flush_r <= 1'b1;
            end
        end
    end

    // Continuity threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_r <= `RFA_CONTINUITY_FUNCTION_THR_RST;
        end else if (wr && paddr == `RFA_ADDR_CONTINUITY_FUNCTION && pwdata[31:10] == 22'h0
            && pwdata[9:0] >= `RFA_CONTINUITY_FUNCTION_THR_MIN && pwdata[9:0] <= `RFA_CONTINUITY_FUNCTION_THR_MAX) begin
            thr_r <= pwdata[9:0];
        end
    end

    // Per-function filter setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                fcnt_r[i] <= `RFA_FCOUNT_RST;
                ftype_r[i] <= 1'b0;
            end
        end else if (wr && paddr == `RFA_ADDR_FILTER_ON_INDICATOR) begin
            if (pwdata[6:0] >= `RFA_FCOUNT_MIN && pwdata[6:0] <= `RFA_FCOUNT_MAX) begin
                fcnt_r[func_r] <= pwdata[6:0];
            end
            ftype_r[func_r] <= pwdata[8];
        end
    end

    // ----------------------------------------
    // Ranging
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                rng_r[i] <= (i == 6) ? `RFA_CONTINUITY_FUNCTION_RANGE : 3'h0;
                auto_r[i] <= 1'b0;
            end
        end else if (wr && paddr == `RFA_ADDR_RANGE && !single_range) begin
            if (pwdata[`RFA_RNG_UP_BIT]) begin
                auto_r[func_r] <= 1'b0;
                if (cur_rng < `RFA_NRANGES - 3'h1) begin
                    rng_r[func_r] <= cur_rng + 3'h1;
                end
            end else if (pwdata[`RFA_RNG_DN_BIT]) begin
                auto_r[func_r] <= 1'b0;
                if (cur_rng != 3'h0) begin
                    rng_r[func_r] <= cur_rng - 3'h1;
                end
            end else if (pwdata[`RFA_RNG_AUTO_BIT]) begin
                auto_r[func_r] <= !auto_r[func_r];
            end
        end else if (conv_valid && auto_r[func_r] && !single_range) begin
            if (mag >= fs + fs / 64'd5 && cur_rng < `RFA_NRANGES - 3'h1) begin
                rng_r[func_r] <= cur_rng + 3'h1;
            end else if (mag <= fs / 64'd10 && cur_rng != 3'h0) begin
                rng_r[func_r] <= cur_rng - 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Overflow and beep
    // ----------------------------------------
    always_comb begin
        mag = conv_data[W-1] ? 64'h0 - 64'(conv_data) : 64'(conv_data);
        fs = 64'(FULL_SCALE);
        for (int i = 0; i < 5; i++) begin
            if (3'(i) < cur_rng) begin
                fs = fs * 64'd10;
            end
        end
        // Top range and diode have no headroom
        exempt = (cur_rng == `RFA_NRANGES - 3'h1) || func_r == rfa_pkg::RFA_DIODE;
        limit = exempt ? fs : fs + fs / 64'd5;
        if (func_r == rfa_pkg::RFA_DIODE) begin
            limit = 64'(`RFA_DIODE_LIMIT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_r <= 1'b0;
            beep <= 1'b0;
        end else if (conv_valid) begin
            ovf_r <= mag > limit;
            beep <= func_r == rfa_pkg::RFA_CONTINUITY_FUNCTION && mag < 64'(thr_r) * 64'd1000000;
        end
    end
    assign overflow = ovf_r;

    // ----------------------------------------
    // Averaging
    // ----------------------------------------
    rfa_avg #(.DEPTH(DEPTH), .W(W)) u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .flush(flush_r),
        .repeat_mode(ftype_r[func_r]),
        .count(fcnt_r[func_r]),
        .in_valid(conv_valid && filter_on_indicator_en_r && !no_filter),
        .in_data(conv_data),
        .out_valid(avg_valid),
        .out_data(avg_data)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else if (filter_on_indicator_en_r && !no_filter) begin
            rd_valid <= avg_valid;
            rd_data <= avg_data;
        end else begin
            rd_valid <= conv_valid;
            rd_data <= conv_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= 32'h0;
        end else if (rd_valid) begin
            result_r <= 32'(rd_data);
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        prdata = 32'h0;
        if (rd) begin
            case (paddr)
                `RFA_ADDR_CTRL: prdata = {23'h0, filter_on_indicator_en_r, 2'h0, diode_r, 1'b0, func_r};
                `RFA_ADDR_FILTER_ON_INDICATOR: prdata = {23'h0, ftype_r[func_r], 1'b0, fcnt_r[func_r]};
                `RFA_ADDR_CONTINUITY_FUNCTION: prdata = {22'h0, thr_r};
                `RFA_ADDR_RANGE: prdata = {25'h0, auto_r[func_r], 3'h0, cur_rng};
                `RFA_ADDR_STAT: prdata = {29'h0, beep, ovf_r, filter_on_indicator_en_r};
                `RFA_ADDR_RESULT: prdata = result_r;
                default: prdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_thr_range: assert property (@(posedge pclk) disable iff (!presetn)
        thr_r >= `RFA_CONTINUITY_FUNCTION_THR_MIN && thr_r <= `RFA_CONTINUITY_FUNCTION_THR_MAX) else $error("threshold out of span");
    chk_continuity_function_fast: assert property (@(posedge pclk) disable iff (!presetn)
        func_r == rfa_pkg::RFA_CONTINUITY_FUNCTION |-> conv_rate == rfa_pkg::RFA_FAST) else $error("continuity_function rate");
    chk_diode_med: assert property (@(posedge pclk) disable iff (!presetn)
        func_r == rfa_pkg::RFA_DIODE |-> conv_rate == rfa_pkg::RFA_MED) else $error("diode rate");
    chk_diode_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        conv_valid && func_r == rfa_pkg::RFA_DIODE && mag > `RFA_DIODE_LIMIT |=> overflow)
        else $error("diode overflow missed");
    chk_continuity_function_beep: assert property (@(posedge pclk) disable iff (!presetn)
        conv_valid && func_r != rfa_pkg::RFA_CONTINUITY_FUNCTION |=> !beep) else $error("beep outside continuity");
    chk_step_one: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `RFA_ADDR_RANGE && !single_range && pwdata[0] && cur_rng < 3'h4
        |=> range_sel == $past(range_sel) + 3'h1) else $error("range step");
    chk_step_cancel: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `RFA_ADDR_RANGE && !single_range && (pwdata[0] || pwdata[1])
        |=> !auto_r[$past(func_r)]) else $error("step kept auto");
    chk_auto_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `RFA_ADDR_RANGE && single_range |=> !auto_r[$past(func_r)])
        else $error("auto on single range");
    chk_unfiltered: assert property (@(posedge pclk) disable iff (!presetn)
        conv_valid && no_filter |=> rd_valid) else $error("continuity_function or diode filtered");
    chk_indicator: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == `RFA_ADDR_CTRL && pwdata[8] |=> filter_on_indicator != $past(filter_on_indicator))
        else $error("filter toggle");
    cov_beep: cover property (@(posedge pclk) beep);
    cov_ovf: cover property (@(posedge pclk) overflow);
    cov_uprange: cover property (@(posedge pclk) auto_r[0] && $rose(rng_r[0][0]));
endmodule // rfa_top

// >>> rfa_map.svh
// Register offsets, field positions, reset values and limits for the reading filter.
// Included by the package users; definitions only.
`ifndef RFA_MAP_SVH
`define RFA_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RFA_ADDR_CTRL 12'h000
`define RFA_ADDR_FILTER_ON_INDICATOR 12'h004
`define RFA_ADDR_CONTINUITY_FUNCTION 12'h008
`define RFA_ADDR_RANGE 12'h00c
`define RFA_ADDR_STAT 12'h010
`define RFA_ADDR_RESULT 12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RFA_CTRL_FUNC_LSB 0
`define RFA_CTRL_DIODE_LSB 4
`define RFA_CTRL_FTOG_BIT 8
`define RFA_RNG_UP_BIT 0
`define RFA_RNG_DN_BIT 1
`define RFA_RNG_AUTO_BIT 2

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define RFA_CONTINUITY_FUNCTION_THR_RST 10'h00a
`define RFA_CONTINUITY_FUNCTION_THR_MIN 10'h001
`define RFA_CONTINUITY_FUNCTION_THR_MAX 10'h3e8
`define RFA_FCOUNT_MIN 7'h01
`define RFA_FCOUNT_MAX 7'h64
`define RFA_FCOUNT_RST 7'h0a
`define RFA_DIODE_LIMIT 32'h0098_9680
`define RFA_CONTINUITY_FUNCTION_RANGE 3'h3
`define RFA_NRANGES 3'h5

`endif

// >>> rfa_pkg.sv
// Types shared by the reading filter files.
// Assumes nothing beyond a SystemVerilog compiler.
package rfa_pkg;
    typedef enum logic [2:0] {
        RFA_DCV, RFA_ACV, RFA_DCI, RFA_ACI, RFA_OHM, RFA_TEMP, RFA_CONTINUITY_FUNCTION, RFA_DIODE
    } rfa_func_e;
    typedef enum logic [1:0] {RFA_FAST, RFA_MED, RFA_SLOW} rfa_rate_e;
    typedef enum logic [1:0] {RFA_I1MA, RFA_I100UA, RFA_I10UA} rfa_diode_e;
endpackage

// >>> rfa_avg.sv
// Averaging store: moving or repeating mean of up to DEPTH conversions.
// Assumes one conversion strobe at a time from logic on the same clock.
module rfa_avg #(
    parameter int DEPTH = 100,
    parameter int W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic flush,
    input wire logic repeat_mode,
    input wire logic [6:0] count,
    // Sample in, average out
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    output logic out_valid,
    output logic signed [W-1:0] out_data
);
    logic signed [W-1:0] mem [DEPTH];
    logic [6:0] wptr_r;
    logic [6:0] fill_r;
    logic signed [W+7:0] sum_r;
    logic signed [W+7:0] sum_nxt;
    logic full;

    assign full = (fill_r == count);

    always_comb begin
        sum_nxt = sum_r + (W+8)'(in_data);
        if (full && !repeat_mode) begin
            sum_nxt = sum_nxt - mem[wptr_r];
        end
    end

    // Store and pointers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_r <= 7'h00;
            fill_r <= 7'h00;
            sum_r <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= 1'b0;
            if (flush) begin
                wptr_r <= 7'h00;
                fill_r <= 7'h00;
                sum_r <= '0;
            end else if (in_valid) begin
                mem[wptr_r] <= in_data;
                wptr_r <= (wptr_r + 7'h01 >= count) ? 7'h00 : wptr_r + 7'h01;
                if ((full ? fill_r : fill_r + 7'h01) == count) begin
                    out_valid <= 1'b1;
                    out_data <= W'(sum_nxt / $signed({1'b0, count}));
                end
                if (repeat_mode && fill_r + 7'h01 == count) begin
                    fill_r <= 7'h00;
                    sum_r <= '0;
                    wptr_r <= 7'h00;
                end else begin
                    if (!full) begin
                        fill_r <= fill_r + 7'h01;
                    end
                    sum_r <= sum_nxt;
                end
            end
        end
    end

    chk_avg_flush: assert property (@(posedge pclk) disable iff (!presetn)
        flush |=> !out_valid) else $error("average after flush");
    chk_avg_fill: assert property (@(posedge pclk) disable iff (!presetn)
        out_valid |-> $past(in_valid)) else $error("average without sample");
    cov_avg_out: cover property (@(posedge pclk) out_valid && !repeat_mode);
    cov_avg_rep: cover property (@(posedge pclk) out_valid && repeat_mode);
endmodule // rfa_avg

// >>> rfa_adc_model.sv
// Converter model: hands one reading conversion to the filter per call.
// Assumes pclk comes from the bench and that only one caller sends at a time.
module rfa_adc_model (
    // Clock
    input wire logic pclk,
    // Conversion stream
    output logic conv_valid,
    output logic signed [31:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        conv_valid = 1'b0;
        conv_data = 32'h0000_0000;
    end

    // ----------------------------------------
    // Conversion delivery
    // ----------------------------------------
    task automatic send(input logic [31:0] v, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        conv_valid <= 1'b1;
        conv_data <= v;
        @(posedge pclk);
        conv_valid <= 1'b0;
        // Idle data inverted so a stale value never passes for a fresh one
        conv_data <= ~v;
    endtask
endmodule // rfa_adc_model

// >>> rfa_top_tb.sv
// Bench for the reading filter: APB tasks, converter model, level checks.
// Assumes rfa_pkg, rfa_top and rfa_adc_model are compiled before it.
`include "rfa_map.svh"
module rfa_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] a_ctl = `RFA_ADDR_CTRL;
    localparam logic [11:0] a_flt = `RFA_ADDR_FILTER_ON_INDICATOR;
    localparam logic [11:0] a_thr = `RFA_ADDR_CONTINUITY_FUNCTION;
    localparam logic [11:0] a_rng = `RFA_ADDR_RANGE;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, last_err, conv_valid, beep, overflow, filter_on_indicator, rd_valid;
    logic signed [31:0] conv_data, rd_data;
    logic [2:0] range_sel;
    rfa_pkg::rfa_rate_e conv_rate;
    rfa_pkg::rfa_diode_e diode_current;
    int err_count = 0, n_compared = 0, cyc = 0;
    logic [31:0] q[$];
    logic [31:0] thr_in[4] = '{32'h000, 32'h3e9, 32'h3e8, 32'h001};
    logic [31:0] thr_ex[4] = '{32'h00a, 32'h00a, 32'h3e8, 32'h001};
    logic [31:0] mv[5] = '{32'h10, 32'h20, 32'h30, 32'h40, 32'h50};
    logic [31:0] rp[6] = '{32'hffff_fff6, 32'hffff_fff6, 32'hffff_fff5, 32'h1e, 32'h3c, 32'h5a};

    rfa_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .conv_valid, .conv_data, .conv_rate, .diode_current, .range_sel, .beep,
        .overflow, .filter_on_indicator, .rd_valid, .rd_data);
    rfa_adc_model adc_u (.pclk, .conv_valid, .conv_data);

    initial begin
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------
    // Reading monitor and hang guard
    // ----------------------------------------
    always @(posedge pclk) begin
        if (rd_valid === 1'b1) q.push_back(rd_data);
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 32'h4e20) begin
            err_count++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task print_verdict();
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    task ex(input logic [31:0] e);
        chk(q.size() > 0 ? q.pop_front() : 32'hxxxx_xxxx, e);
    endtask
    // Waits on pready through any wait states: the hang guard ends a stuck access
    task acc();
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        acc();
        @(negedge pclk);
    endtask
    task rd(input logic [11:0] a);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= a;
        acc();
    endtask
    task cv(input logic [31:0] v, input int g = 0);
        adc_u.send(v, g);
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    task fn(input rfa_pkg::rfa_func_e f);
        wr(a_ctl, {29'h0, f});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(a_thr);
        chk(rdat, 32'h00a);
        chk(32'(diode_current), 32'(rfa_pkg::RFA_I1MA));
        chk(32'(filter_on_indicator), 32'h0);
        rd(12'h018);
        chk({last_err, rdat[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(a_thr, thr_in[i]);
            rd(a_thr);
            chk(rdat, thr_ex[i]);
        end
        wr(a_thr, 32'h00a);
        // Diode: current codes, fixed rate, 10 V limit, auto refused
        for (int i = 0; i < 4; i++) begin
            wr(a_ctl, {26'h0, i[1:0], 1'b0, 3'h7});
            chk(32'(diode_current), i < 3 ? i : 2);
        end
        chk(32'(conv_rate), 32'(rfa_pkg::RFA_MED));
        cv(32'h0098_9680);
        chk(32'(overflow), 32'h0);
        cv(32'h0098_9681);
        chk(32'(overflow), 32'h1);
        wr(a_rng, 32'h4);
        rd(a_rng);
        chk(rdat & 32'h40, 32'h0);
        // Continuity: fixed rate and range, beep strictly below threshold
        fn(rfa_pkg::RFA_CONTINUITY_FUNCTION);
        chk(32'(conv_rate), 32'(rfa_pkg::RFA_FAST));
        wr(a_rng, 32'h1);
        chk(32'(range_sel), 32'(`RFA_CONTINUITY_FUNCTION_RANGE));
        cv(32'h0098_967f);
        chk(32'(beep), 32'h1);
        cv(32'h0098_9680);
        chk(32'(beep), 32'h0);
        // Manual steps, overrange edges, per-function range
        fn(rfa_pkg::RFA_DCV);
        wr(a_rng, 32'h1);
        wr(a_rng, 32'h1);
        chk(32'(range_sel), 32'h2);
        wr(a_rng, 32'h2);
        chk(32'(range_sel), 32'h1);
        cv(32'h00b7_1b00);
        chk(32'(overflow), 32'h0);
        cv(32'hff48_e4ff);
        chk(32'(overflow), 32'h1);
        q.delete();
        cv(32'h004c_4b40);
        ex(32'h004c_4b40);
        fn(rfa_pkg::RFA_OHM);
        chk(32'(range_sel), 32'h0);
        fn(rfa_pkg::RFA_DCV);
        chk(32'(range_sel), 32'h1);
        repeat (3) wr(a_rng, 32'h1);
        cv(32'h7735_9400);
        chk(32'(overflow), 32'h0);
        repeat (3) wr(a_rng, 32'h2);
        // Autorange at exactly 120 and 10 percent, then cancel
        wr(a_rng, 32'h4);
        cv(32'h00b7_1b00);
        chk(32'(range_sel), 32'h2);
        cv(32'h0098_9680);
        chk(32'(range_sel), 32'h1);
        wr(a_rng, 32'h4);
        rd(a_rng);
        chk(rdat & 32'h47, 32'h01);
        wr(a_rng, 32'h4);
        wr(a_rng, 32'h1);
        rd(a_rng);
        chk(rdat & 32'h47, 32'h02);
        // Moving average with a flush after a partial fill
        wr(a_ctl, 32'h100);
        chk(32'(filter_on_indicator), 32'h1);
        wr(a_flt, 32'h004);
        q.delete();
        cv(32'h08);
        cv(32'h08);
        wr(a_flt, 32'h004);
        foreach (mv[i]) cv(mv[i], i);
        ex(32'h28);
        ex(32'h38);
        chk(q.size(), 32'h0);
        // Repeating mode, truncation toward zero, count limits
        wr(a_flt, 32'h103);
        foreach (rp[i]) cv(rp[i]);
        ex(32'hffff_fff6);
        ex(32'h3c);
        chk(q.size(), 32'h0);
        wr(a_flt, 32'h165);
        rd(a_flt);
        chk(rdat & 32'h17f, 32'h103);
        wr(a_flt, 32'h064);
        rd(a_flt);
        chk(rdat & 32'h17f, 32'h064);
        fn(rfa_pkg::RFA_ACV);
        rd(a_flt);
        chk(rdat & 32'h17f, 32'h00a);
        fn(rfa_pkg::RFA_DCV);
        rd(a_flt);
        chk(rdat & 32'h17f, 32'h064);
        // Continuity passes readings unaveraged with the filter on
        fn(rfa_pkg::RFA_CONTINUITY_FUNCTION);
        q.delete();
        cv(32'h05);
        ex(32'h05);
        wr(a_ctl, 32'h100);
        chk(32'(filter_on_indicator), 32'h0);
        print_verdict();
    end
endmodule // rfa_top_tb
